// ---- design/ccsu_pkg.sv ----
// package for the cpu context status unit: map, fields, states
package ccsu_pkg;
  localparam logic [31:0] CCSU_OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] CCSU_OFF_FLAGS = 32'h0000_0004;
  localparam logic [31:0] CCSU_OFF_IPTR = 32'h0000_0008;
  localparam logic [31:0] CCSU_OFF_BASE = 32'h0000_000C;
  localparam logic [31:0] CCSU_OFF_HOLD = 32'h0000_0010;
  localparam logic [31:0] CCSU_OFF_STAT = 32'h0000_0014;
  localparam logic [15:0] CCSU_FLAGS_RST = 16'h0000;
  localparam logic [15:0] CCSU_RESET_VEC = 16'h0000;
  localparam logic [15:0] CCSU_IRQ_VEC_BASE = 16'h0000;
  localparam int CCSU_BIT_LGT = 0;
  localparam int CCSU_BIT_AGT = 1;
  localparam int CCSU_BIT_EQ = 2;
  localparam int CCSU_BIT_CARRY = 3;
  localparam int CCSU_BIT_OVF = 4;
  localparam int CCSU_BIT_PAR = 5;
  localparam int CCSU_BIT_XOP = 6;
  localparam int CCSU_MASK_LSB = 12;
  localparam logic [15:0] CCSU_FLAGS_WMASK = 16'hF07F;
  localparam logic [3:0] CCSU_REG_LINK = 4'hD;
  localparam logic [3:0] CCSU_REG_IPTR = 4'hE;
  localparam logic [3:0] CCSU_REG_FLAGS = 4'hF;
  localparam logic [3:0] CCSU_REG_IOBASE = 4'hC;
  localparam logic [3:0] CCSU_REG_SHIFT = 4'h0;
  localparam logic [1:0] CCSU_RESP_OK = 2'b00;
  localparam logic [1:0] CCSU_RESP_ERR = 2'b10;
  localparam logic [2:0] CCSU_OP_NOP = 3'h0;
  localparam logic [2:0] CCSU_OP_ADD = 3'h1;
  localparam logic [2:0] CCSU_OP_CMP = 3'h2;
  localparam logic [2:0] CCSU_OP_JMP = 3'h3;
  localparam logic [2:0] CCSU_OP_RET = 3'h4;
  localparam logic [2:0] CCSU_OP_MOVX = 3'h5;

  typedef enum {
    CS_BOOT0, CS_BOOT1, CS_FETCH, CS_EXT1, CS_EXT2, CS_RDA, CS_RDB,
    CS_WRR, CS_RET13, CS_RET14, CS_RET15, CS_CHECK, CS_VEC0,
    CS_SAV15, CS_SAV14, CS_SAV13, CS_VEC1, CS_HALT
  } ccsu_state_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ccsu_mem_t;

  typedef struct packed {
    ccsu_state_t st;
    ccsu_mem_t mem;
    logic [15:0] base;
    logic [15:0] iptr;
    logic [15:0] flags;
    logic [15:0] hold;
    logic [15:0] ext;
    logic [15:0] opA;
    logic [15:0] opB;
    logic [15:0] nBase;
    logic [3:0] level;
    logic run;
    logic [1:0] wPend;
    logic [15:0] wAddr;
    logic [15:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ccsu_state_s_t;
endpackage : ccsu_pkg

// ---- design/ccsu_core.sv ----
// cpu context status unit: fetch sequencing, flags, context switching
// How it works
// RULE1: register n lives in memory at base pointer plus two times n.
// RULE2: next sequential instruction word is at instruction pointer plus two.
// RULE3: extra instruction words fetched at following even addresses.
// RULE4: taken jump loads the target into the instruction pointer.
// RULE5: flags word: lgt, agt, eq, carry, ovf, parity, xop, mask 12-15.
// RULE6: compare sets bit 0 unsigned greater, bit 1 signed greater.
// RULE7: compare sets equal bit when both words match, else clears it.
// RULE8: result instructions compare their result against zero.
// RULE9: operands read from memory, result written back, no accumulator.
// RULE10: add takes fetch, two operand reads and one result write.
// RULE11: words at even byte addresses, even byte is the high half.
// RULE12: byte addresses are sixteen bits wide, 64k bytes.
// RULE13: pending interrupt checked after each instruction completes.
// RULE14: context switch first reads new base pointer from vector.
// RULE15: old flags to R15, pointer to R14, base to R13, in order.
// RULE16: then second vector word loads the instruction pointer.
// RULE17: return reloads base, pointer and flags from R13, R14, R15.
// RULE18: R12 io base, R0 shift count, R11 and R13-15 linkage.
// RULE19: registers 1 to 15 may index; register 0 may not.
// RULE20: fetched word kept in holder and decoded into multi steps.
// RULE21: reset loads base and pointer from the first two words.
// RULE22: level n vector pair at byte address four times n.
// RULE23: pointer and base keep bit zero cleared.
`timescale 1ns/1ps
module ccsu_core
  import ccsu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // external word memory, one request held until memAck
  output logic memReq,
  output logic memWrite,
  output logic [15:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic [15:0] memRdata,
  input wire logic memAck,
  // interrupt request level, 0 means none
  input wire logic [3:0] irqLevel,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic running,
  output logic [15:0] flagsOut
);
  ccsu_state_s_t q, d;

  // register n of the set whose base pointer is b
  function automatic logic [15:0] regAddr(input logic [15:0] b,
                                          input logic [3:0] n);
    regAddr = b + {11'h000, n, 1'b0}; // [RULE1] [RULE11]
  endfunction : regAddr

  // word accesses only ever target an even byte address
  function automatic logic [15:0] evenWord(input logic [15:0] a);
    evenWord = {a[15:1], 1'b0}; // [RULE11] [RULE23]
  endfunction : evenWord

  // compare helper: bits 0..2 only
  function automatic logic [2:0] cmpBits(input logic [15:0] a,
                                         input logic [15:0] b);
    cmpBits[0] = a > b; // [RULE6]
    cmpBits[1] = $signed(a) > $signed(b); // [RULE6]
    cmpBits[2] = a == b; // [RULE7]
  endfunction : cmpBits

  // decode: [15:13] op, [11:8] reg A, [7:4] reg B or index, [3:0] dest
  logic [2:0] op;
  logic [3:0] fA, fB, fD;
  logic [16:0] sum;
  logic [15:0] sum16;
  logic ovf;
  logic [3:0] mask;
  logic awHit, wHit;
  logic [15:0] wVal;
  logic [15:0] idxTarget;

  always_comb begin
    op = q.hold[15:13]; // [RULE20]
    fA = q.hold[11:8];
    fB = q.hold[7:4];
    fD = q.hold[3:0];
    sum = {1'b0, q.opA} + {1'b0, q.opB};
    sum16 = sum[15:0];
    ovf = (q.opA[15] == q.opB[15]) && (sum16[15] != q.opA[15]);
    mask = q.flags[15:CCSU_MASK_LSB];
    awHit = s_axi_awvalid && !q.wPend[0];
    wHit = s_axi_wvalid && !q.wPend[1];
    wVal = q.wData;
  end

  always_comb begin
    d = q;
    idxTarget = q.opB;
    // memory handshake: request clears on acknowledge
    if (q.mem.req && memAck) begin
      d.mem.req = 1'b0;
    end
    // register bus write side
    if (awHit) begin
      d.wPend[0] = 1'b1;
      d.wAddr = s_axi_awaddr[15:0];
    end
    if (wHit) begin
      d.wPend[1] = 1'b1;
      d.wData = s_axi_wdata[15:0];
      d.wStrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.wPend == 2'b11 && !q.bvalid) begin
      d.wPend = 2'b00;
      d.bvalid = 1'b1;
      d.bresp = CCSU_RESP_OK;
      unique case (q.wAddr)
        CCSU_OFF_CTRL[15:0]: begin
          if (q.wStrb[0]) begin
            d.run = wVal[0];
          end
        end
        CCSU_OFF_FLAGS[15:0]: begin
          if (q.wStrb[0]) begin
            d.flags[7:0] = wVal[7:0] & CCSU_FLAGS_WMASK[7:0]; // [RULE5]
          end
          if (q.wStrb[1]) begin
            d.flags[15:8] = wVal[15:8] & CCSU_FLAGS_WMASK[15:8]; // [RULE5]
          end
        end
        default: begin
          d.bresp = CCSU_RESP_ERR;
        end
      endcase
    end
    // ready straight from a flop; follows the pending bits
    d.awReady = !d.wPend[0];
    d.wReady = !d.wPend[1];
    // register bus read side
    d.arready = 1'b0;
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // answer only once the address handshake has happened
    if (q.arready) begin
      d.rvalid = 1'b1;
    end
    if (s_axi_arvalid && !q.arready && !q.rvalid) begin
      d.arready = 1'b1;
      d.rresp = CCSU_RESP_OK;
      unique case (s_axi_araddr[15:0])
        CCSU_OFF_CTRL[15:0]: d.rdata = {31'h0000_0000, q.run};
        CCSU_OFF_FLAGS[15:0]: d.rdata = {16'h0000, q.flags};
        CCSU_OFF_IPTR[15:0]: d.rdata = {16'h0000, q.iptr};
        CCSU_OFF_BASE[15:0]: d.rdata = {16'h0000, q.base};
        CCSU_OFF_HOLD[15:0]: d.rdata = {16'h0000, q.hold};
        CCSU_OFF_STAT[15:0]: d.rdata = {27'h0000000, 5'(q.st)};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = CCSU_RESP_ERR;
        end
      endcase
    end

    // sequencer; a step advances only when its memory access completes
    if (!q.mem.req || memAck) begin
      d.mem.write = 1'b0;
      unique case (q.st)
        CS_BOOT0: begin
          if (!q.mem.req) begin
            d.mem = '{1'b1, 1'b0, CCSU_RESET_VEC, 16'h0000}; // [RULE21]
          end else begin
            d.base = {memRdata[15:1], 1'b0}; // [RULE21] [RULE23]
            d.mem = '{1'b1, 1'b0, CCSU_RESET_VEC + 16'h0002, 16'h0000};
            d.st = CS_BOOT1;
          end
        end
        CS_BOOT1: begin
          d.iptr = {memRdata[15:1], 1'b0}; // [RULE21] [RULE23]
          d.st = CS_CHECK;
        end
        CS_CHECK: begin
          // level must not exceed the mask, as in a priority scheme
          if (irqLevel != 4'h0 && irqLevel <= mask) begin // [RULE13]
            d.level = irqLevel;
            d.mem = '{1'b1, 1'b0,
                      CCSU_IRQ_VEC_BASE + {10'h000, irqLevel, 2'b00},
                      16'h0000}; // [RULE14] [RULE22]
            d.st = CS_VEC0;
          end else if (q.run) begin
            d.mem = '{1'b1, 1'b0, q.iptr, 16'h0000};
            d.iptr = q.iptr + 16'h0002; // [RULE2] [RULE12]
            d.st = CS_FETCH;
          end
        end
        CS_FETCH: begin
          d.hold = memRdata; // [RULE20]
          if (memRdata[12]) begin
            d.mem = '{1'b1, 1'b0, q.iptr, 16'h0000};
            d.iptr = q.iptr + 16'h0002; // [RULE3]
            d.st = CS_EXT1;
          end else begin
            d.st = CS_RDA;
          end
        end
        CS_EXT1: begin
          d.ext = memRdata;
          if (op == CCSU_OP_MOVX) begin
            // third word only for indexed form
            d.mem = '{1'b1, 1'b0, q.iptr, 16'h0000};
            d.iptr = q.iptr + 16'h0002; // [RULE3]
            d.st = CS_EXT2;
          end else begin
            d.st = CS_RDA;
          end
        end
        CS_EXT2: begin
          d.opB = memRdata;
          d.st = CS_RDA;
        end
        CS_RDA: begin
          if (!q.mem.req) begin
            unique case (op)
              CCSU_OP_JMP: begin
                d.iptr = {q.ext[15:1], 1'b0}; // [RULE4] [RULE23]
                d.st = CS_CHECK;
              end
              CCSU_OP_RET: begin
                d.mem = '{1'b1, 1'b0, regAddr(q.base, CCSU_REG_LINK),
                          16'h0000}; // [RULE17] [RULE18]
                d.st = CS_RET13;
              end
              CCSU_OP_ADD, CCSU_OP_CMP, CCSU_OP_MOVX: begin
                d.mem = '{1'b1, 1'b0, regAddr(q.base, fA), 16'h0000};
              end
              default: d.st = CS_CHECK;
            endcase
          end else begin
            d.opA = memRdata; // [RULE9]
            if (op == CCSU_OP_MOVX) begin
              // second read is the index register named by field B
              d.mem = '{1'b1, 1'b0, regAddr(q.base, fB),
                        16'h0000}; // [RULE19]
              d.st = CS_RDB;
            end else begin
              d.mem = '{1'b1, 1'b0, regAddr(q.base, fB), 16'h0000};
              d.st = CS_RDB;
            end
          end
        end
        CS_RDB: begin
          if (op == CCSU_OP_CMP) begin
            d.flags[2:0] = cmpBits(q.opA, memRdata); // [RULE6] [RULE7]
            d.st = CS_CHECK;
          end else if (op == CCSU_OP_MOVX) begin
            // indexed store target; write operand A
            // R0 holds a shift count, so it never adds an index
            if (fB != CCSU_REG_SHIFT) begin // [RULE18] [RULE19]
              idxTarget = q.opB + memRdata;
            end
            d.mem = '{1'b1, 1'b1, evenWord(idxTarget), q.opA}; // [RULE11]
            d.st = CS_WRR;
          end else begin
            d.opB = memRdata; // [RULE9]
            d.st = CS_WRR;
            d.mem = '{1'b1, 1'b1, regAddr(q.base, fD),
                      q.opA + memRdata}; // [RULE9] [RULE10]
          end
        end
        CS_WRR: begin
          if (op == CCSU_OP_ADD) begin
            d.flags[2:0] = cmpBits(sum16, 16'h0000); // [RULE8]
            d.flags[CCSU_BIT_CARRY] = sum[16];
            d.flags[CCSU_BIT_OVF] = ovf;
            d.flags[CCSU_BIT_PAR] = ^sum16[15:8];
          end else begin
            d.flags[2:0] = cmpBits(q.opA, 16'h0000); // [RULE8]
          end
          d.st = CS_CHECK; // [RULE13]
        end
        CS_RET13: begin
          d.nBase = {memRdata[15:1], 1'b0}; // [RULE17] [RULE23]
          d.mem = '{1'b1, 1'b0, regAddr(q.base, CCSU_REG_IPTR), 16'h0000};
          d.st = CS_RET14;
        end
        CS_RET14: begin
          d.iptr = {memRdata[15:1], 1'b0}; // [RULE17] [RULE23]
          d.mem = '{1'b1, 1'b0, regAddr(q.base, CCSU_REG_FLAGS), 16'h0000};
          d.st = CS_RET15;
        end
        CS_RET15: begin
          d.flags = memRdata & CCSU_FLAGS_WMASK; // [RULE17] [RULE5]
          d.base = q.nBase; // [RULE17]
          d.st = CS_CHECK;
        end
        CS_VEC0: begin
          d.nBase = {memRdata[15:1], 1'b0}; // [RULE14] [RULE23]
          d.mem = '{1'b1, 1'b1, regAddr({memRdata[15:1], 1'b0},
                    CCSU_REG_FLAGS), q.flags}; // [RULE15]
          d.st = CS_SAV15;
        end
        CS_SAV15: begin
          d.mem = '{1'b1, 1'b1, regAddr(q.nBase, CCSU_REG_IPTR),
                    q.iptr}; // [RULE15]
          d.st = CS_SAV14;
        end
        CS_SAV14: begin
          d.mem = '{1'b1, 1'b1, regAddr(q.nBase, CCSU_REG_LINK),
                    q.base}; // [RULE15]
          d.st = CS_SAV13;
        end
        CS_SAV13: begin
          d.mem = '{1'b1, 1'b0, CCSU_IRQ_VEC_BASE +
                    {10'h000, q.level, 2'b10}, 16'h0000}; // [RULE16]
          d.base = q.nBase;
          // serviced level lowers the mask so it cannot nest itself
          d.flags[15:CCSU_MASK_LSB] = q.level - 4'h1;
          d.st = CS_VEC1;
        end
        CS_VEC1: begin
          d.iptr = {memRdata[15:1], 1'b0}; // [RULE16] [RULE23]
          d.st = CS_CHECK;
        end
        CS_HALT: begin
          // never entered; kept so a stray state still finds its way back
          d.st = CS_CHECK;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= CS_BOOT0;
      q.flags <= CCSU_FLAGS_RST;
      q.run <= 1'b1;
      q.awReady <= 1'b1;
      q.wReady <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign memReq = q.mem.req;
  assign memWrite = q.mem.write;
  assign memAddr = q.mem.addr;
  assign memWdata = q.mem.wdata;
  assign s_axi_awready = q.awReady;
  assign s_axi_wready = q.wReady;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign running = q.run;
  assign flagsOut = q.flags;
endmodule : ccsu_core

// ---- verif/ccsu_core_properties.sv ----
// port checker for the cpu context status unit
`timescale 1ns/1ps
module ccsu_core_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic memAck,
  input wire logic [15:0] flagsOut,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_even_addr: assert property (
    memReq |-> !memAddr[0]) else $error("odd memory address");
  a_req_held: assert property (
    memReq && !memAck |=> memReq && $stable(memAddr) &&
    $stable(memWrite) && $stable(memWdata))
    else $error("memory request changed before ack");
  a_boot_fetch: assert property (
    $rose(rst_n) |-> ##[0:4] (memReq && !memWrite && memAddr == 16'h0000))
    else $error("no boot read of word zero");
  a_flags_resv: assert property (
    flagsOut[11:7] == 5'h00) else $error("reserved flag bits set");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  a_write_resp: assert property (
    s_axi_wvalid && s_axi_wready && s_axi_awvalid |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_read_resp: assert property (
    s_axi_arvalid && !s_axi_rvalid |-> ##[1:3] s_axi_rvalid)
    else $error("read not answered");
endmodule : ccsu_core_properties

bind ccsu_core ccsu_core_properties chk (.clk(clk), .rst_n(rst_n),
  .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
  .memWdata(memWdata), .memAck(memAck), .flagsOut(flagsOut),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ---- verif/ccsu_mem_model.sv ----
// word memory model answering the core's request handshake
`timescale 1ns/1ps
module ccsu_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic [15:0] memRdata,
  output logic memAck
);
  logic [15:0] ram [0:32767];
  logic [16:0] trace [$];
  logic [1:0] waitQ;
  always @(posedge clk) begin
    if (!rst_n) begin
      memAck <= 1'b0;
      waitQ <= 2'h0;
      memRdata <= 16'hA5A5;
      trace.delete();
    end else if (memReq && !memAck && (!slow || waitQ == 2'h3)) begin
      memAck <= 1'b1;
      waitQ <= 2'h0;
      trace.push_back({memWrite, memAddr});
      if (memWrite) begin
        ram[memAddr[15:1]] <= memWdata;
      end
      memRdata <= memWrite ? ~memRdata : ram[memAddr[15:1]];
    end else begin
      memAck <= 1'b0;
      waitQ <= (memReq && !memAck) ? waitQ + 2'h1 : 2'h0;
      // bus floats between answers: invert the held word every cycle
      memRdata <= ~memRdata;
    end
  end
endmodule : ccsu_mem_model

// ---- verif/tb.sv ----
// self-checking bench for the cpu context status unit
`timescale 1ns/1ps
module tb;
  import ccsu_pkg::*;
  logic clk, rst_n, slow, memReq, memWrite, memAck, running;
  logic [15:0] memAddr, memWdata, memRdata, flagsOut, lfsr, o1, o2, o3, o4;
  logic [3:0] irqLevel, wstrb;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int bad_count, checks_done;
  int cycles = 0;
  localparam logic [16:0] BOOT [13] = '{17'h00000, 17'h00002, 17'h00200,
    17'h00102, 17'h00104, 17'h10106, 17'h00202, 17'h00108, 17'h0010A,
    17'h00204, 17'h00206, 17'h00240, 17'h00242};
  localparam logic [16:0] SWAP [16] = '{17'h0000C, 17'h1031E, 17'h1031C,
    17'h1031A, 17'h0000E, 17'h00400, 17'h00402, 17'h00404, 17'h00302,
    17'h00304, 17'h10510, 17'h00406, 17'h0031A, 17'h0031C, 17'h0031E,
    17'h00240};
  ccsu_core DUT (.clk(clk), .rst_n(rst_n), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .irqLevel(irqLevel),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .running(running), .flagsOut(flagsOut));
  ccsu_mem_model mem (.clk(clk), .rst_n(rst_n), .slow(slow),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hung handshake ends here rather than stalling the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand
  function automatic logic [2:0] cmp_flags(input logic [15:0] a,
      input logic [15:0] b);
    return {a == b, $signed(a) > $signed(b), a > b};
  endfunction : cmp_flags
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
      output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd
  task automatic poke(input logic [15:0] a, input logic [15:0] v);
    mem.ram[a[15:1]] = v;
  endtask : poke
  task automatic run_trial(input logic [15:0] a, input logic [15:0] b,
      input logic [15:0] c, input logic [15:0] d, input logic s);
    logic [31:0] v;
    logic [1:0] r;
    int k;
    rst_n <= 1'b0;
    slow <= s;
    irqLevel <= 4'h0;
    @(posedge clk);
    poke(16'h0000, 16'h0100);
    poke(16'h0002, 16'h0200);
    poke(16'h0102, a);
    poke(16'h0104, b);
    poke(16'h0108, c);
    poke(16'h010A, d);
    poke(16'h0200, 16'h2123);
    poke(16'h0202, 16'h4450);
    poke(16'h0204, 16'h7000);
    poke(16'h0206, 16'h0240);
    poke(16'h0240, 16'h7000);
    poke(16'h0242, 16'h0240);
    poke(16'h000C, 16'h0300);
    poke(16'h000E, 16'h0400);
    poke(16'h0400, 16'hB120);
    poke(16'h0402, 16'h0000);
    poke(16'h0404, 16'h0500);
    poke(16'h0406, 16'h8000);
    poke(16'h0302, a);
    poke(16'h0304, 16'h0010);
    poke(16'h0510, ~a);
    repeat (11) @(posedge clk);
    rst_n <= 1'b1;
    while (mem.trace.size() < 13) @(posedge clk);
    for (k = 0; k < 13; k++) begin
      check("boot trace", 32'(BOOT[k]),
        32'(mem.trace[k]));
    end
    check("sum", {16'h0000, a + b}, {16'h0000, mem.ram[16'h0083]});
    check("cmp flags", {29'h0, cmp_flags(c, d)},
      {29'h0, flagsOut[2:0]});
    axi_rd(CCSU_OFF_BASE, v, r);
    check("base", 32'h0000_0100, v);
    axi_rd(CCSU_OFF_CTRL, v, r);
    check("run bit", 32'h0000_0001, v);
    axi_rd(32'h0000_0040, v, r);
    check("unmapped resp", {30'h0, CCSU_RESP_ERR}, {30'h0, r});
    check("unmapped data", 32'h0000_0000, v);
    axi_wr(32'h0000_0040, 32'h0000_0001, r);
    check("unmapped wresp", {30'h0, CCSU_RESP_ERR}, {30'h0, r});
    axi_wr(CCSU_OFF_CTRL, 32'h0000_0000, r);
    check("running off", 32'h0000_0000, {31'h0, running});
    axi_wr(CCSU_OFF_CTRL, 32'h0000_0001, r);
    check("running on", 32'h0000_0001, {31'h0, running});
    axi_wr(CCSU_OFF_FLAGS, 32'h0000_FF80, r);
    check("write resp", {30'h0, CCSU_RESP_OK}, {30'h0, r});
    axi_rd(CCSU_OFF_FLAGS, v, r);
    check("flags reg", 32'h0000_F000, v);
    irqLevel <= 4'h3;
    while (mem.trace[mem.trace.size() - 1] !== 17'h1031A) @(posedge clk);
    irqLevel <= 4'h0;
    for (k = 0; k < mem.trace.size(); k++) begin
      if (mem.trace[k] === 17'h0000C) break;
    end
    while (mem.trace.size() < k + 16) @(posedge clk);
    for (int j = 0; j < 16; j++) begin
      check("swap trace", 32'(SWAP[j]),
        32'(mem.trace[k + j]));
    end
    check("indexed store", {16'h0, a},
      {16'h0, mem.ram[16'h0288]});
    check("saved flags", 32'h0000_F000, {16'h0, mem.ram[16'h018F]});
    check("saved ip", 32'h0000_0240, {16'h0, mem.ram[16'h018E]});
    check("saved base", 32'h0000_0100, {16'h0, mem.ram[16'h018D]});
    check("restored flags", 32'h0000_F000, {16'h0, flagsOut});
  endtask : run_trial
  initial begin
    rst_n = 1'b0;
    slow = 1'b0;
    irqLevel = 4'h0;
    awaddr = 32'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    araddr = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    checks_done = 0;
    bad_count = 0;
    lfsr = 16'h003E;
    run_trial(16'h7FFF, 16'h0001, 16'h1234, 16'h1234, 1'b0);
    run_trial(16'hFFFF, 16'h0001, 16'h8000, 16'h7FFF, 1'b1);
    for (int t = 0; t < 4; t++) begin
      lfsr = next_rand(lfsr);
      o1 = lfsr;
      lfsr = next_rand(lfsr);
      o2 = lfsr;
      lfsr = next_rand(lfsr);
      o3 = lfsr;
      lfsr = next_rand(lfsr);
      o4 = lfsr;
      run_trial(o1, o2, o3, o4, t[0]);
    end
    complete_run();
  end
endmodule : tb
